// File: src/rlc_addr.sv
// operand address resolution for byte instructions
module rlc_addr
	import rlc_pkg::*;
(
	input wire logic [7:0] addr_field,
	input wire logic bank_mode,
	input wire logic ext_set_en,
	input wire logic [3:0] bank_select_register,
	input wire logic [7:0] index_base,
	output logic [11:0] eff_addr,
	output logic indexed
);
	// indexed mode takes the low access region when the extended set is on
	assign indexed = (bank_mode == RLC_MODE_ACCESS) && ext_set_en
		&& (addr_field <= RLC_INDEX_MAX);
	// access bank: low part from bank 0, upper part from the top bank
	wire [3:0] access_bank = (addr_field < RLC_ACCESS_SPLIT) ? 4'h0 : RLC_TOP_BANK;
	// index sum stays inside the 12-bit space; the carry out of the low byte lands in bit 8
	wire [11:0] index_addr = 12'({4'h0, index_base} + {4'h0, addr_field});
	assign eff_addr = indexed ? index_addr
		: (bank_mode == RLC_MODE_BANKED) ? {bank_select_register, addr_field}
		: {access_bank, addr_field};
endmodule // rlc_addr

// File: src/rlc_core.sv
// Summary of operation
// - rotate left, bit 7 to carry, carry in
// - destination zero writes working register only
// - destination one writes back to memory
// - access mode resolves address in access bank
// - banked mode prefixes bank select register
// - extended set, access, offset<=95: indexed
module rlc_core
	import rlc_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic start,
	input wire logic [7:0] addr_field,
	input wire logic dest_sel,
	input wire logic bank_mode,
	input wire logic ext_set_en,
	input wire logic [3:0] bank_select_register,
	input wire logic [7:0] index_base,
	input wire logic [7:0] mem_rdata,
	input wire logic carry_in,
	output logic [11:0] mem_addr_r,
	output logic mem_rd_r,
	output logic mem_we_r,
	output logic [7:0] mem_wdata_r,
	output logic [7:0] wreg_r,
	output logic carry_r,
	output logic neg_r,
	output logic zero_r,
	output logic flags_we_r,
	output logic busy_r,
	output logic done_r
);
	import rlc_pkg::*;

	// phase of the current instruction cycle
	rlc_phase_t phase_r;
	rlc_phase_t phase_nxt;
	// latched instruction fields, held stable over the cycle
	logic dest_r;
	logic [7:0] opnd_r; // operand byte read in q2
	wire [11:0] eff_addr; // resolved operand address, combinational; mem_addr_r latches it at decode

	// rotation used by the datapath; the checks build the rotated byte on their own
	function automatic logic [8:0] rot_left(input logic [7:0] v, input logic c);
		rot_left = {v, c};
	endfunction

	// address resolution lives in its own module
	rlc_addr u_addr
	(
		.addr_field(addr_field),
		.bank_mode(bank_mode),
		.ext_set_en(ext_set_en),
		.bank_select_register(bank_select_register),
		.index_base(index_base),
		.eff_addr(eff_addr),
		.indexed()
	);

	wire [8:0] rot = rot_left(opnd_r, carry_in);
	wire idle = !busy_r;
	wire take = idle && start;
	wire to_file = (dest_r == RLC_DEST_FILE);

	// phase sequencer: q1 decode, q2 read, q3 process, q4 write
	always_comb
	begin
		case (phase_r)
			RLC_Q1: phase_nxt = take ? RLC_Q2 : RLC_Q1;
			RLC_Q2: phase_nxt = RLC_Q3;
			RLC_Q3: phase_nxt = RLC_Q4;
			RLC_Q4: phase_nxt = RLC_Q1;
			default: phase_nxt = RLC_Q1;
		endcase
	end

	// sequencer and request latch; busy covers q2..q4
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			phase_r <= RLC_Q1;
			busy_r <= 1'b0;
			dest_r <= RLC_DEST_FILE;
			mem_addr_r <= RLC_ADDR_RST;
			mem_rd_r <= 1'b0;
		end
		else
		begin
			phase_r <= phase_nxt;
			busy_r <= (phase_nxt != RLC_Q1);
			// destination and address are captured at decode; carry_in is not latched and is still read live in q3
			if (take)
			begin
				dest_r <= dest_sel;
				mem_addr_r <= eff_addr;
			end
			mem_rd_r <= take;
		end
	end

	// operand read in q2; the rotation is combinational on the held operand
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			opnd_r <= 8'h00;
		end
		else
		begin
			// memory answers in the same phase as the read strobe
			if (phase_r == RLC_Q2)
				opnd_r <= mem_rdata;
		end
	end

	// write-back in q4: to the file or to the working register, never both
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			mem_we_r <= 1'b0;
			mem_wdata_r <= 8'h00;
			wreg_r <= RLC_WREG_RST;
			carry_r <= 1'b0;
			neg_r <= 1'b0;
			zero_r <= 1'b0;
			flags_we_r <= 1'b0;
			done_r <= 1'b0;
		end
		else
		begin
			mem_we_r <= (phase_r == RLC_Q3) && to_file;
			flags_we_r <= (phase_r == RLC_Q3);
			done_r <= (phase_r == RLC_Q3);
			if (phase_r == RLC_Q3)
			begin
				mem_wdata_r <= rot[7:0];
				if (!to_file)
					wreg_r <= rot[7:0];
				carry_r <= rot[8];
				neg_r <= rot[7];
				zero_r <= (rot[7:0] == 8'h00);
			end
		end
	end

	// checks
	// carry flag takes the operand's old top bit
	a_rot_carry: assert property (@(posedge clk) disable iff (!rstn)
		done_r |-> carry_r == $past(opnd_r[7], 1))
		else $error("carry does not hold old bit 7");

	// result is the operand shifted up with the old carry in bit 0
	a_rot_value: assert property (@(posedge clk) disable iff (!rstn)
		(phase_r == RLC_Q3) |=> mem_wdata_r
			== {$past(opnd_r[6:0], 1), $past(carry_in, 1)})
		else $error("rotated byte wrong");

	// destination zero: working register loaded, memory left alone
	a_wreg_dest: assert property (@(posedge clk) disable iff (!rstn)
		(phase_r == RLC_Q3 && !to_file) |=> !mem_we_r
			&& wreg_r == {$past(opnd_r[6:0], 1), $past(carry_in, 1)})
		else $error("w destination wrote memory or missed w");

	// destination one: write strobe issued, working register untouched
	a_file_dest: assert property (@(posedge clk) disable iff (!rstn)
		(phase_r == RLC_Q3 && to_file) |=> mem_we_r && $stable(wreg_r))
		else $error("file destination misbehaved");

	// the working register moves only on a destination-zero write
	a_wreg_kept: assert property (@(posedge clk) disable iff (!rstn)
		!(phase_r == RLC_Q3 && !to_file) |=> $stable(wreg_r))
		else $error("working register changed without a w write");

	// memory is written only in the completing phase
	a_we_gated: assert property (@(posedge clk) disable iff (!rstn)
		mem_we_r |-> done_r)
		else $error("memory write outside completion");

	// write-back must land on the location that was read
	a_addr_held: assert property (@(posedge clk) disable iff (!rstn)
		busy_r |=> $stable(mem_addr_r))
		else $error("operand address moved mid-instruction");

	// banked mode: bank select register on top of the address field
	a_banked_addr: assert property (@(posedge clk) disable iff (!rstn)
		(take && bank_mode == RLC_MODE_BANKED) |=> mem_addr_r
			== {$past(bank_select_register), $past(addr_field)})
		else $error("banked address wrong");

	// access mode outside the indexed range: low part bank 0, rest top bank
	a_access_addr: assert property (@(posedge clk) disable iff (!rstn)
		(take && bank_mode == RLC_MODE_ACCESS
			&& !(ext_set_en && addr_field <= RLC_INDEX_MAX))
			|=> mem_addr_r[7:0] == $past(addr_field)
			&& mem_addr_r[11:8]
			== (($past(addr_field) < RLC_ACCESS_SPLIT) ? 4'h0 : RLC_TOP_BANK))
		else $error("access address wrong");

	// indexed literal offset: base plus offset, wrapped to the address width
	a_index_addr: assert property (@(posedge clk) disable iff (!rstn)
		(take && bank_mode == RLC_MODE_ACCESS && ext_set_en && addr_field <= RLC_INDEX_MAX)
			|=> mem_addr_r == 12'({4'h0, $past(index_base)} + {4'h0, $past(addr_field)}))
		else $error("indexed address wrong");

	// negative is the old bit 6, zero when the rotated byte is empty
	a_flags_nz: assert property (@(posedge clk) disable iff (!rstn)
		done_r |-> neg_r == $past(opnd_r[6], 1)
			&& zero_r == ({$past(opnd_r[6:0], 1), $past(carry_in, 1)} == 8'h00))
		else $error("n or z flag wrong");

	// flags move only when an instruction completes
	a_flags_kept: assert property (@(posedge clk) disable iff (!rstn)
		(phase_r != RLC_Q3) |=> $stable({carry_r, neg_r, zero_r}))
		else $error("flags changed outside completion");

	// one instruction cycle: four phases from decode to done
	a_one_cycle: assert property (@(posedge clk) disable iff (!rstn)
		take |-> ##3 done_r)
		else $error("instruction not done in one cycle");

	// busy spans the three phases after decode, then the core is free again
	a_busy_span: assert property (@(posedge clk) disable iff (!rstn)
		take |=> busy_r [*3] ##1 !busy_r)
		else $error("busy window wrong");

	// operand read strobe lasts one phase
	a_read_pulse: assert property (@(posedge clk) disable iff (!rstn)
		take |=> mem_rd_r ##1 !mem_rd_r)
		else $error("read strobe not a single pulse");

	// done is a single-phase pulse
	a_done_pulse: assert property (@(posedge clk) disable iff (!rstn)
		done_r |=> !done_r)
		else $error("done held too long");
endmodule // rlc_core

// File: src/rlc_pkg.sv
package rlc_pkg;
	// data and address widths of the byte core
	localparam int RLC_DATA_W = 8;
	localparam int RLC_BANK_W = 4;
	localparam int RLC_ADDR_W = 12;
	// destination select encodings
	localparam logic RLC_DEST_WREG = 1'b0;
	localparam logic RLC_DEST_FILE = 1'b1;
	// bank mode encodings
	localparam logic RLC_MODE_ACCESS = 1'b0;
	localparam logic RLC_MODE_BANKED = 1'b1;
	// access bank split: offsets below 60h map to bank 0, the rest to the top bank
	localparam logic [7:0] RLC_ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] RLC_TOP_BANK = 4'hF;
	// highest offset handled by indexed literal offset mode
	localparam logic [7:0] RLC_INDEX_MAX = 8'h5F;
	// reset values
	localparam logic [7:0] RLC_WREG_RST = 8'h00;
	localparam logic [11:0] RLC_ADDR_RST = 12'h000;
	// phases of one instruction cycle, one-hot
	typedef enum logic [3:0]
	{
		RLC_Q1 = 4'b0001,
		RLC_Q2 = 4'b0010,
		RLC_Q3 = 4'b0100,
		RLC_Q4 = 4'b1000
	} rlc_phase_t;
endpackage

// File: test/rotate_left_through_carry_tb.sv
// self-checking bench for the rotate-left-through-carry instruction core
module rotate_left_through_carry_tb
	import rlc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic start = 1'b0;
	logic dest_sel = 1'b0;
	logic bank_mode = 1'b0;
	logic ext_set_en = 1'b0;
	logic carry_in = 1'b0;
	logic [7:0] addr_field = 8'h00;
	logic [7:0] index_base = 8'h00;
	logic [7:0] mem_rdata = 8'h00;
	logic [3:0] bank_select_register = 4'h0;
	logic [11:0] mem_addr_r;
	logic [7:0] mem_wdata_r, wreg_r;
	logic mem_rd_r, mem_we_r, carry_r, neg_r, zero_r, flags_we_r, busy_r, done_r;
	int n_mismatch = 0;
	int checked = 0;
	int seed = 4;
	// model of the working register, only moved by destination-zero ops and the mid-run reset
	logic [7:0] w_exp = RLC_WREG_RST;

	rlc_core i_rlc_core (.clk, .rstn, .start, .addr_field, .dest_sel, .bank_mode,
		.ext_set_en, .bank_select_register, .index_base, .mem_rdata, .carry_in,
		.mem_addr_r, .mem_rd_r, .mem_we_r, .mem_wdata_r, .wreg_r, .carry_r,
		.neg_r, .zero_r, .flags_we_r, .busy_r, .done_r);

	// free-running 200 MHz clock
	initial
	begin
		forever #2.5 clk = ~clk;
	end

	// one compare, counted; widths up to the address bus
	task chk(input logic [11:0] seen, input logic [11:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task close_out;
		$display("mismatches %0d comparisons %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// one instruction: model first, then drive and compare at every result
	task run_op(input logic [7:0] a, input logic d, m, x, input logic [3:0] b,
		input logic [7:0] ib, dat, input logic c);
		logic [7:0] res;
		logic [11:0] ea;
		int n;
		res = {dat[6:0], c};
		if (m)
			ea = {b, a};
		else if (x && a <= RLC_INDEX_MAX)
			ea = {4'h0, ib} + {4'h0, a};
		else
			ea = {(a < RLC_ACCESS_SPLIT) ? 4'h0 : RLC_TOP_BANK, a};
		@(posedge clk);
		start <= 1'b1;
		addr_field <= a;
		dest_sel <= d;
		bank_mode <= m;
		ext_set_en <= x;
		bank_select_register <= b;
		index_base <= ib;
		mem_rdata <= dat;
		carry_in <= c;
		@(posedge clk);
		start <= 1'b0;
		#1;
		chk(mem_rd_r, 1'b1);
		chk(mem_addr_r, ea);
		chk(busy_r, 1'b1);
		n = 1;
		// bounded wait: a hang here is a failure, not a stall
		while (done_r !== 1'b1 && n < 8)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(12'(n), 12'd3);
		if (n >= 8)
		begin
			n_mismatch++;
			close_out();
		end
		chk(carry_r, dat[7]);
		chk(neg_r, res[7]);
		chk(zero_r, res == 8'h00);
		chk(flags_we_r, 1'b1);
		chk(mem_we_r, d);
		if (d)
			chk(mem_wdata_r, res);
		else
			w_exp = res;
		chk(wreg_r, w_exp);
	endtask

	// reset, worked example, zero result, index boundary sweep, then random ops
	initial
	begin
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		run_op(8'h12, RLC_DEST_WREG, RLC_MODE_ACCESS, 1'b0, 4'h3, 8'h10, 8'hE6, 1'b0);
		run_op(8'h60, RLC_DEST_FILE, RLC_MODE_ACCESS, 1'b1, 4'h3, 8'h20, 8'h80, 1'b0);
		// offsets 5C..63 straddle the indexed limit; base F0 exercises the carry
		for (int k = 0; k < 8; k++)
			run_op(8'h5C + 8'(k), k[0], 1'b0, 1'b1, 4'h7, 8'hF0, 8'(k * 37), k[1]);
		for (int k = 0; k < 60; k++)
			run_op(8'($random(seed)), 1'($random(seed)), 1'($random(seed)),
				1'($random(seed)), 4'($random(seed)), 8'($random(seed)),
				8'($random(seed)), 1'($random(seed)));
		// mid-run reset: working register, flags and busy return to reset values
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		#1;
		chk(wreg_r, RLC_WREG_RST);
		chk(carry_r, 1'b0);
		chk(busy_r, 1'b0);
		w_exp = RLC_WREG_RST;
		// banked mode with the extended set on, offset 80h above the indexed limit; zero result sets the zero flag
		run_op(8'h80, RLC_DEST_WREG, RLC_MODE_BANKED, 1'b1, 4'h5, 8'h00, 8'h00, 1'b0);
		close_out();
	end
endmodule // rotate_left_through_carry_tb
